// ==== design/pic_regs.vh ====
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// register byte addresses (printed offsets are multiples of four, except the port request register)
`define PIC_ADDR_REQ_LOW    12'hfc0
`define PIC_ADDR_REQ_PORT   12'hfc3
`define PIC_ADDR_CTRL       12'hfc4
`define PIC_ADDR_EN_LOW     12'hfc8
`define PIC_ADDR_EN_PORT    12'hfcc
`define PIC_ADDR_PRIO_LOW   12'hfd0
`define PIC_ADDR_PRIO_PORT  12'hfd4
`define PIC_ADDR_VECTOR     12'hfd8

// printed index of the port request register (not a multiple of four)
`define PIC_IDX_REQ_PORT    12'hfc3

// pending_request_low fields
`define PIC_BIT_TIMER_ONE   6
`define PIC_BIT_TIMER_ZERO  5
`define PIC_BIT_SERIAL_RX   4
`define PIC_BIT_SERIAL_TX   3
`define PIC_BIT_CONVERTER   0
`define PIC_REQ_LOW_MASK    8'h79

// control register fields
`define PIC_BIT_GLOBAL_EN   7

// reset values
`define PIC_RST_REQ         8'h00
`define PIC_RST_EN          8'h00
`define PIC_RST_PRIO        16'h0000

// priority level codes
`define PIC_LEVEL_OFF       2'h0
`define PIC_LEVEL_ONE       2'h1
`define PIC_LEVEL_TWO       2'h2
`define PIC_LEVEL_THREE     2'h3

// vector code for top-level sources
`define PIC_VEC_TOP         5'h1f
`define PIC_VEC_NONE        5'h00

`endif

// ==== design/pic_controller.v ====
// Overview of operation
// - enable instr, return, or write 1 sets enable
// - disable instr, write 0, reset, traps clear enable
// - core acknowledge clears the global enable
// - three priority levels per maskable source
// - level three beats two beats one
// - fixed source order breaks ties in level
// - reset, watchdog, traps outrank all maskables (here the trap instruction raises no request, it only clears enable)
// - pulse latches pending bit until cleared
// - acknowledge clears the served pending bit
// - software write of zero clears pending
// - forward winner only while globally enabled
// - low register: timers, serial, converter layout
// - port register: pins, shared lowvolt, comparator
// - watchdog and oscillator traps bypass registers
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"

module pic_controller (
	input  wire        clock_i,
	input  wire        reset_i,
	input  wire [11:0] avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	input  wire [7:0]  req_low_pulse_i,
	input  wire [7:0]  req_port_pulse_i,
	input  wire        enable_interrupt_instr_i,
	input  wire        return_from_interrupt_instr_i,
	input  wire        disable_interrupt_instr_i,
	input  wire        trap_instr_i,
	input  wire        illegal_instr_trap_i,
	input  wire        primary_osc_fail_i,
	input  wire        watchdog_osc_fail_i,
	input  wire        watchdog_irq_i,
	input  wire        irq_ack_i,
	output reg         irq_o,
	output reg  [4:0]  irq_vector_o,
	output reg  [1:0]  irq_level_o,
	output wire        global_irq_enable_o
);

	reg        global_irq_enable;
	reg [7:0]  pending_request_low;
	reg [7:0]  pending_request_port;
	reg [7:0]  enable_low;
	reg [7:0]  enable_port;
	reg [15:0] prio_low;
	reg [15:0] prio_port;
	reg        bus_ack;
	reg        top_pend;
	reg [4:0]  next_vector;
	reg [1:0]  next_level;
	reg        next_valid;
	reg [15:0] next_clr;

	wire [15:0] pend_all;
	wire [15:0] en_all;
	wire [31:0] prio_all;
	wire        access;
	wire        wr_req;
	wire        rd_req;
	wire        top_event;
	integer     k;

	// pending update: written zeros clear, ack clears, pulse wins
	function [7:0] pending_next;
		input [7:0] cur;
		input [7:0] clr;
		input       wsel;
		input [7:0] wdata;
		input [7:0] pulse;
		begin
			pending_next = (cur & ~clr & (wsel ? wdata : 8'hff)) | pulse;
		end
	endfunction

	function [1:0] level_of;
		input [31:0] p;
		input [3:0]  idx;
		begin
			level_of = p[idx*2 +: 2];
		end
	endfunction

	assign pend_all = {pending_request_port, pending_request_low};
	assign en_all   = {enable_port, enable_low};
	assign prio_all = {prio_port, prio_low};
	assign access   = avs_read_i | avs_write_i;
	// one wait cycle, the answer is given on the second edge
	assign avs_waitrequest_o = access & ~bus_ack;
	// writes land at the edge where waitrequest is low
	assign wr_req = avs_write_i & bus_ack;
	assign rd_req = avs_read_i & ~bus_ack;
	assign global_irq_enable_o = global_irq_enable;
	assign top_event = watchdog_irq_i | primary_osc_fail_i | watchdog_osc_fail_i
		| illegal_instr_trap_i;

	// arbitration of maskable sources
	always @* begin
		next_valid  = 1'b0;
		next_vector = `PIC_VEC_NONE;
		next_level  = `PIC_LEVEL_OFF;
		for (k = 0; k < 16; k = k + 1) begin
			if (pend_all[k] && en_all[k] && level_of(prio_all, k[3:0]) != `PIC_LEVEL_OFF
				&& level_of(prio_all, k[3:0]) >= next_level) begin
				next_valid  = 1'b1;
				next_vector = {1'b0, k[3:0]};
				next_level  = level_of(prio_all, k[3:0]);
			end
		end
		if (top_pend) begin
			next_valid  = 1'b1;
			next_vector = `PIC_VEC_TOP;
			next_level  = `PIC_LEVEL_THREE;
		end
	end

	// acknowledge clears the currently presented source
	always @* begin
		next_clr = 16'h0000;
		if (irq_ack_i && irq_o && irq_vector_o != `PIC_VEC_TOP) begin
			next_clr[irq_vector_o[3:0]] = 1'b1;
		end
	end

	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= access & ~bus_ack;
		end
	end

	// global enable
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			global_irq_enable <= 1'b0;
		end else if (disable_interrupt_instr_i | trap_instr_i | illegal_instr_trap_i
			| primary_osc_fail_i | watchdog_osc_fail_i) begin
			global_irq_enable <= 1'b0;
		end else if (irq_ack_i && irq_o) begin
			global_irq_enable <= 1'b0;
		end else if (enable_interrupt_instr_i | return_from_interrupt_instr_i) begin
			global_irq_enable <= 1'b1;
		end else if (wr_req && avs_address_i == `PIC_ADDR_CTRL) begin
			global_irq_enable <= avs_writedata_i[`PIC_BIT_GLOBAL_EN];
		end
	end

	// pending bits, a new pulse wins over any clear
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			pending_request_low  <= `PIC_RST_REQ;
			pending_request_port <= `PIC_RST_REQ;
			top_pend             <= 1'b0;
		end else begin
			pending_request_low <= pending_next(pending_request_low, next_clr[7:0],
				wr_req && avs_address_i == `PIC_ADDR_REQ_LOW, avs_writedata_i[7:0],
				req_low_pulse_i) & `PIC_REQ_LOW_MASK;
			pending_request_port <= pending_next(pending_request_port, next_clr[15:8],
				wr_req && avs_address_i == `PIC_ADDR_REQ_PORT, avs_writedata_i[7:0],
				req_port_pulse_i);
			top_pend <= top_event | (top_pend & ~(irq_ack_i && irq_o
				&& irq_vector_o == `PIC_VEC_TOP));
		end
	end

	// configuration registers
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			enable_low  <= `PIC_RST_EN;
			enable_port <= `PIC_RST_EN;
			prio_low    <= `PIC_RST_PRIO;
			prio_port   <= `PIC_RST_PRIO;
		end else if (wr_req) begin
			case (avs_address_i)
				`PIC_ADDR_EN_LOW: begin
					enable_low <= avs_writedata_i[7:0] & `PIC_REQ_LOW_MASK;
				end
				`PIC_ADDR_EN_PORT: begin
					enable_port <= avs_writedata_i[7:0];
				end
				`PIC_ADDR_PRIO_LOW: begin
					prio_low <= avs_writedata_i[15:0];
				end
				`PIC_ADDR_PRIO_PORT: begin
					prio_port <= avs_writedata_i[15:0];
				end
				default: begin
					enable_low <= enable_low;
				end
			endcase
		end
	end

	// request to core
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o        <= 1'b0;
			irq_vector_o <= `PIC_VEC_NONE;
			irq_level_o  <= `PIC_LEVEL_OFF;
		end else begin
			irq_o        <= next_valid & global_irq_enable & ~(irq_ack_i & irq_o);
			irq_vector_o <= next_vector;
			irq_level_o  <= next_level;
		end
	end

	// read data
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (rd_req) begin
			case (avs_address_i)
				`PIC_ADDR_REQ_LOW:   avs_readdata_o <= {24'h000000, pending_request_low};
				`PIC_ADDR_REQ_PORT:  avs_readdata_o <= {24'h000000, pending_request_port};
				`PIC_ADDR_CTRL:      avs_readdata_o <= {24'h000000, global_irq_enable, 7'h00};
				`PIC_ADDR_EN_LOW:    avs_readdata_o <= {24'h000000, enable_low};
				`PIC_ADDR_EN_PORT:   avs_readdata_o <= {24'h000000, enable_port};
				`PIC_ADDR_PRIO_LOW:  avs_readdata_o <= {16'h0000, prio_low};
				`PIC_ADDR_PRIO_PORT: avs_readdata_o <= {16'h0000, prio_port};
				`PIC_ADDR_VECTOR:    avs_readdata_o <= {24'h000000, next_valid, next_level,
					next_vector};
				default:             avs_readdata_o <= 32'h00000000;
			endcase
		end
	end

endmodule // pic_controller
`default_nettype wire

// ==== testbench/pic_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module pic_monitor (
	input wire logic       clock_i,
	input wire logic       reset_i,
	input wire logic       enable_interrupt_instr_i,
	input wire logic       return_from_interrupt_instr_i,
	input wire logic       disable_interrupt_instr_i,
	input wire logic       trap_instr_i,
	input wire logic       illegal_instr_trap_i,
	input wire logic       primary_osc_fail_i,
	input wire logic       watchdog_osc_fail_i,
	input wire logic       watchdog_irq_i,
	input wire logic       irq_ack_i,
	input wire logic       irq_o,
	input wire logic [4:0] irq_vector_o,
	input wire logic [1:0] irq_level_o,
	input wire logic       global_irq_enable_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (reset_i);
	wire kill = disable_interrupt_instr_i | trap_instr_i | illegal_instr_trap_i
		| primary_osc_fail_i | watchdog_osc_fail_i;
	wire took = irq_ack_i & irq_o;
	en_set_a: assert property ((enable_interrupt_instr_i | return_from_interrupt_instr_i)
		& !kill & !took |=> global_irq_enable_o) else $error("enable not set");
	en_clr_a: assert property (kill |=> !global_irq_enable_o)
		else $error("enable not cleared");
	ack_dis_a: assert property (took |=> !global_irq_enable_o)
		else $error("enable kept after ack");
	ack_drop_a: assert property (took |=> !irq_o)
		else $error("request kept after ack");
	poll_quiet_a: assert property (!global_irq_enable_o [*2] |-> !irq_o)
		else $error("request while disabled");
	lvl_range_a: assert property (irq_o |-> irq_level_o != 2'h0)
		else $error("request with level zero");
	top_lvl_a: assert property (irq_o && irq_vector_o == 5'h1f |-> irq_level_o == 2'h3)
		else $error("top source not level three");
	wdog_top_a: assert property (watchdog_irq_i ##1 global_irq_enable_o [*2]
		|-> irq_o && irq_vector_o == 5'h1f) else $error("watchdog not served");
endmodule // pic_monitor
bind pic_controller pic_monitor mon (.*);
`default_nettype wire

// ==== testbench/pic_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
	input  wire logic       clock_i,
	input  wire logic       irq_i,
	input  wire logic [3:0] delay_i,
	output var  logic       ack_o
);
	logic [3:0] wait_cnt;
	initial ack_o = 1'b0;
	initial wait_cnt = 4'h0;
	// acks a standing request after delay_i cycles
	always @(posedge clock_i) begin
		ack_o <= 1'b0;
		if (!irq_i || ack_o)
			wait_cnt <= 4'h0;
		else if (wait_cnt < delay_i)
			wait_cnt <= wait_cnt + 4'h1;
		else
			ack_o <= 1'b1;
	end
endmodule // pic_core_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_ack_i, irq_o;
	logic enable_interrupt_instr_i, return_from_interrupt_instr_i, disable_interrupt_instr_i;
	logic trap_instr_i, illegal_instr_trap_i, primary_osc_fail_i, watchdog_osc_fail_i;
	logic watchdog_irq_i, global_irq_enable_o;
	logic [31:0] avs_writedata_i, avs_readdata_o, seed, r, q;
	logic [11:0] avs_address_i;
	logic [7:0]  req_low_pulse_i, req_port_pulse_i, ins;
	logic [4:0]  irq_vector_o;
	logic [1:0]  irq_level_o;
	logic [3:0]  dly;
	int          mismatches, compares, n, pm, pri, b, bl;
	int          exq[$];
	assign {watchdog_irq_i, watchdog_osc_fail_i, primary_osc_fail_i, illegal_instr_trap_i,
		trap_instr_i, disable_interrupt_instr_i, return_from_interrupt_instr_i,
		enable_interrupt_instr_i} = ins;
	pic_controller uut (.*);
	pic_core_model core (.clock_i(clock_i), .irq_i(irq_o), .delay_i(dly), .ack_o(irq_ack_i));
	initial forever #10 clock_i = !clock_i;
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		n = 0;
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0 && ++n < 50);
		if (n >= 50)
			mismatches++;
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(q, e);
	endtask
	task automatic rdp();
		rd(12'hfc0, pm & 8'hff);
		rd(12'hfc3, pm >> 8);
	endtask
	task automatic fire(input logic [7:0] i, input logic [7:0] l, input logic [7:0] p);
		ins <= i;
		req_low_pulse_i <= l;
		req_port_pulse_i <= p;
		@(posedge clock_i);
		{ins, req_low_pulse_i, req_port_pulse_i} <= '0;
		@(posedge clock_i);
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#(20 * 20000);
		mismatches++;
		end_of_test();
	end
	initial begin
		{clock_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
		{req_low_pulse_i, req_port_pulse_i, ins, mismatches, compares, pm} = '0;
		dly = 4'hf;
		seed = 32'd45073;
		reset_i = 1'b1;
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
		rd(12'hfc4, 0);
		rd(12'hfe0, 0);
		rdp();
		r = xs();
		fire(0, r[7:0], r[15:8]);
		pm = {r[15:8], r[7:0] & 8'h79};
		chk(irq_o, 0);
		rdp();
		r = xs();
		bus(1, 12'hfc0, r);
		bus(1, 12'hfc3, r >> 8);
		pm &= r;
		rdp();
		$display("test pending done");
		for (int k = 0; k < 8; k++) begin
			bus(1, 12'hfc4, k < 2 ? 0 : 8'h80);
			fire(8'h01 << k, 0, 0);
			chk(global_irq_enable_o, k < 2 || k == 7);
		end
		$display("test enable done");
		bus(1, 12'hfc8, 8'hff);
		bus(1, 12'hfcc, 8'hff);
		repeat (3) begin
			pri = xs();
			bus(1, 12'hfd0, pri);
			bus(1, 12'hfd4, pri >> 16);
			bus(1, 12'hfc4, 0);
			bus(1, 12'hfc0, 0);
			bus(1, 12'hfc3, 0);
			r = xs();
			fire(8'h80, r[7:0], r[15:8]);
			pm = {r[15:8], r[7:0] & 8'h79};
			exq = '{31};
			do begin
				b = -1;
				bl = 0;
				for (int i = 0; i < 16; i++)
					if (pm[i] && pri[2*i+:2] >= bl && pri[2*i+:2] > 0) begin
						b = i;
						bl = pri[2*i+:2];
					end
				if (b >= 0) begin
					exq.push_back(b);
					pm[b] = 0;
				end
			end while (b >= 0);
			fire(8'h02, 0, 0);
			foreach (exq[j]) begin
				dly <= 4'(xs());
				n = 0;
				do @(posedge clock_i); while (irq_o !== 1'b1 && ++n < 40);
				chk(irq_o, 1);
				chk(irq_vector_o, exq[j]);
				chk(irq_level_o, exq[j] == 31 ? 3 : pri[2*exq[j]+:2]);
				do @(posedge clock_i); while (global_irq_enable_o !== 1'b0 && ++n < 80);
				if (n >= 80)
					mismatches++;
				fire(8'h02, 0, 0);
			end
			repeat (3) @(posedge clock_i);
			chk(irq_o, 0);
			rdp();
			rd(12'hfd8, 0);
			$display("test round done");
		end
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
